// ---- hw/nibble_alu_datapath.sv ----
// nibble alu datapath: issue port, skip control, table read sequencer and register port
//
// Local design decisions: the address map and the address-and-strobe port.
module nibble_alu_datapath (
    input  wire logic        clk_sys_i,      // system clock, 25 MHz
    input  wire logic        rstn_i,         // asynchronous reset, active low
    input  wire logic        instr_valid_i,  // instruction offered
    input  wire logic [4:0]  instr_op_i,     // instruction code
    input  wire logic [4:0]  instr_arg_i,    // immediate n, bit j or page p
    output logic             instr_ready_o,  // instruction can be taken
    input  wire logic [3:0]  mem_rdata_i,    // nibble at the data pointer
    output logic             mem_we_o,       // write memory nibble, one cycle
    output logic [3:0]       mem_wdata_o,    // nibble to write
    output logic             rom_req_o,      // rom table fetch, one cycle
    output logic [11:0]      rom_addr_o,     // page and offset of the fetch
    input  wire logic        rom_valid_i,    // rom word returned
    input  wire logic [9:0]  rom_data_i,     // rom word
    output logic             stack_hold_o,   // one stack level in use
    output logic             skip_o,         // next instruction will be skipped
    output logic [3:0]       acc_o,          // accumulator
    output logic [3:0]       aux_o,          // auxiliary nibble register
    output logic [2:0]       page_ofs_o,     // page-offset register
    output logic             carry_flag_o,   // carry flag
    input  wire logic [3:0]  reg_addr_i,     // register byte address
    input  wire logic [31:0] reg_wdata_i,    // register write data
    input  wire logic        reg_we_i,       // register write strobe
    input  wire logic        reg_re_i,       // register read strobe
    output logic [31:0]      reg_rdata_o     // read data, cycle after the strobe
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        nibble_alu_pkg::tbl_state_e fsm;
        logic [3:0]                 acc;
        logic [3:0]                 aux;
        logic [2:0]                 ofs;
        logic                       carry;
        logic                       skip;
        logic                       prev_load;
        logic                       upper_table_bits_flag;
        logic                       ready;
        logic                       mem_we;
        logic [3:0]                 mem_wdata;
        logic                       rom_req;
        logic [11:0]                rom_addr;
        logic                       stack_hold;
        logic [31:0]                rdata;
    } state_s;

    state_s r_r;
    state_s r_nxt;

    logic       take;
    logic       is_load;
    logic       chained;
    logic       exec;
    logic [3:0] alu_acc;
    logic       alu_carry;
    logic [3:0] alu_mem;
    logic       alu_mem_we;
    logic       alu_skip;

    // an instruction is taken only when offered and ready
    assign take    = instr_valid_i & r_r.ready;
    assign is_load = (instr_op_i == 5'(nibble_alu_pkg::OP_LOAD_IMM));
    assign chained = is_load & r_r.prev_load;
    assign exec    = take & ~r_r.skip & ~chained;

    ////////////////////////////////////////////////////////////////////////////
    // alu

    nibble_alu_core u_alu (
        .op_i     (instr_op_i),
        .acc_i    (r_r.acc),
        .mem_i    (mem_rdata_i),
        .carry_i  (r_r.carry),
        .imm_i    (instr_arg_i[3:0]),
        .acc_o    (alu_acc),
        .carry_o  (alu_carry),
        .mem_o    (alu_mem),
        .mem_we_o (alu_mem_we),
        .skip_o   (alu_skip)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next state

    // issue, skip, table sequencing and register port in one place
    always_comb begin
        r_nxt = r_r;
        r_nxt.mem_we = 1'b0;
        r_nxt.rom_req = 1'b0;
        r_nxt.ready = (r_r.fsm == nibble_alu_pkg::ST_IDLE);
        r_nxt.rdata = 32'h0;
        case (r_r.fsm)
            nibble_alu_pkg::ST_IDLE: begin
                if (take) begin
                    // any taken load, run or not, extends a load chain
                    r_nxt.prev_load = is_load;
                    // a skip flag is used up by exactly one instruction
                    r_nxt.skip = 1'b0;
                    if (exec) begin
                        if (instr_op_i == 5'(nibble_alu_pkg::OP_TABLE_READ)) begin
                            r_nxt.rom_addr = {instr_arg_i, r_r.ofs, r_r.acc};
                            r_nxt.rom_req = 1'b1;
                            r_nxt.stack_hold = 1'b1;
                            r_nxt.ready = 1'b0;
                            r_nxt.fsm = nibble_alu_pkg::ST_WAIT;
                        end else begin
                            r_nxt.acc = alu_acc;
                            r_nxt.carry = alu_carry;
                            r_nxt.skip = alu_skip;
                            r_nxt.mem_we = alu_mem_we;
                            r_nxt.mem_wdata = alu_mem;
                            // hold off one cycle so the memory write lands first
                            if (alu_mem_we) begin
                                r_nxt.ready = 1'b0;
                            end
                        end
                    end
                end
            end
            nibble_alu_pkg::ST_WAIT: begin
                r_nxt.ready = 1'b0;
                if (rom_valid_i) begin
                    r_nxt.aux = rom_data_i[7:4];
                    r_nxt.acc = rom_data_i[3:0];
                    if (r_r.upper_table_bits_flag) begin
                        r_nxt.ofs = {1'b0, rom_data_i[9:8]};
                    end
                    r_nxt.stack_hold = 1'b0;
                    r_nxt.ready = 1'b1;
                    r_nxt.fsm = nibble_alu_pkg::ST_IDLE;
                end
            end
            default: begin
                r_nxt.fsm = nibble_alu_pkg::ST_IDLE;
                r_nxt.stack_hold = 1'b0;
            end
        endcase
        // register writes; the page offset may be preset by software
        if (reg_we_i) begin
            case (reg_addr_i)
                nibble_alu_pkg::REG_CTRL: r_nxt.upper_table_bits_flag = reg_wdata_i[nibble_alu_pkg::UPPER_FLAG_BIT];
                nibble_alu_pkg::REG_PAGE_OFS: begin
                    if (!(r_r.fsm == nibble_alu_pkg::ST_WAIT && rom_valid_i && r_r.upper_table_bits_flag)) begin
                        r_nxt.ofs = reg_wdata_i[2:0];
                    end
                end
                default: ;
            endcase
        end
        // register reads, unmapped addresses read zero
        if (reg_re_i) begin
            case (reg_addr_i)
                nibble_alu_pkg::REG_CTRL:     r_nxt.rdata[nibble_alu_pkg::UPPER_FLAG_BIT] = r_r.upper_table_bits_flag;
                nibble_alu_pkg::REG_STATE: begin
                    r_nxt.rdata[nibble_alu_pkg::ACC_LSB +: 4] = r_r.acc;
                    r_nxt.rdata[nibble_alu_pkg::AUX_LSB +: 4] = r_r.aux;
                    r_nxt.rdata[nibble_alu_pkg::OFS_LSB +: 3] = r_r.ofs;
                    r_nxt.rdata[nibble_alu_pkg::CARRY_BIT]    = r_r.carry;
                    r_nxt.rdata[nibble_alu_pkg::SKIP_BIT]     = r_r.skip;
                    r_nxt.rdata[nibble_alu_pkg::BUSY_BIT]     = r_r.stack_hold;
                end
                nibble_alu_pkg::REG_PAGE_OFS: r_nxt.rdata[2:0] = r_r.ofs;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    // the whole state in one flop bank
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            r_r.fsm        <= nibble_alu_pkg::ST_IDLE;
            r_r.acc        <= nibble_alu_pkg::ACC_RST;
            r_r.aux        <= nibble_alu_pkg::AUX_RST;
            r_r.ofs        <= nibble_alu_pkg::OFS_RST;
            r_r.carry      <= nibble_alu_pkg::CARRY_RST;
            r_r.skip       <= 1'b0;
            r_r.prev_load  <= 1'b0;
            r_r.upper_table_bits_flag <= nibble_alu_pkg::UPPER_FLAG_RST;
            r_r.ready      <= 1'b0;
            r_r.mem_we     <= 1'b0;
            r_r.mem_wdata  <= 4'h0;
            r_r.rom_req    <= 1'b0;
            r_r.rom_addr   <= 12'h000;
            r_r.stack_hold <= 1'b0;
            r_r.rdata      <= 32'h0;
        end else begin
            r_r <= r_nxt;
        end
    end

    // outputs straight from the flop bank
    assign instr_ready_o = r_r.ready;
    assign mem_we_o      = r_r.mem_we;
    assign mem_wdata_o   = r_r.mem_wdata;
    assign rom_req_o     = r_r.rom_req;
    assign rom_addr_o    = r_r.rom_addr;
    assign stack_hold_o  = r_r.stack_hold;
    assign skip_o        = r_r.skip;
    assign acc_o         = r_r.acc;
    assign aux_o         = r_r.aux;
    assign page_ofs_o    = r_r.ofs;
    assign carry_flag_o  = r_r.carry;
    assign reg_rdata_o   = r_r.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    // helper values sampled by the checks
    logic [4:0] chk_sum_mem;
    logic [4:0] chk_sum_carry;
    logic [4:0] chk_sum_imm;
    logic [3:0] chk_imm;
    logic [3:0] chk_mask;
    assign chk_sum_mem   = {1'b0, r_r.acc} + {1'b0, mem_rdata_i};
    assign chk_sum_carry = chk_sum_mem + {4'h0, r_r.carry};
    assign chk_imm       = instr_arg_i[3:0];
    assign chk_sum_imm   = {1'b0, r_r.acc} + {1'b0, chk_imm};
    assign chk_mask      = 4'h1 << instr_arg_i[1:0];

    sequence s_table_issue;
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_TABLE_READ);
    endsequence

    sequence s_table_return;
        r_r.fsm == nibble_alu_pkg::ST_WAIT && rom_valid_i;
    endsequence

    a_load_writes_acc: assert property (
        exec && is_load |=> acc_o == $past(chk_imm))
        else $error("load immediate did not reach the accumulator");

    a_load_chain_skip: assert property (
        take && !r_r.skip && chained |=> acc_o == $past(acc_o) && !skip_o)
        else $error("chained load immediate changed the accumulator");

    a_table_fills_regs: assert property (
        s_table_return |=> aux_o == $past(rom_data_i[7:4]) && acc_o == $past(rom_data_i[3:0]))
        else $error("table read data not split into aux and accumulator");

    a_table_addr_form: assert property (
        s_table_issue |=> rom_req_o && rom_addr_o == {$past(instr_arg_i), $past(page_ofs_o), $past(acc_o)})
        else $error("table read address wrong");

    a_table_upper_bits: assert property (
        s_table_return ##0 r_r.upper_table_bits_flag && !reg_we_i |=> page_ofs_o == {1'b0, $past(rom_data_i[9:8])})
        else $error("upper table bits not loaded into page offset");

    a_stack_hold_span: assert property (
        s_table_issue |=> (stack_hold_o && !instr_ready_o) until_with s_table_return)
        else $error("stack level not held during table read");

    a_add_mem_sum: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_ADD_MEM)
        |=> acc_o == $past(chk_sum_mem[3:0]) && carry_flag_o == $past(carry_flag_o))
        else $error("add memory result or carry wrong");

    a_add_carry_sum: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_ADD_MEM_CARRY)
        |=> {carry_flag_o, acc_o} == $past(chk_sum_carry))
        else $error("add memory with carry wrong");

    a_add_imm_skip: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_ADD_IMM)
        |=> skip_o == !$past(chk_sum_imm[4]) && acc_o == $past(chk_sum_imm[3:0]))
        else $error("add immediate skip decision wrong");

    a_rotate_chain: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_ROTATE_RIGHT)
        |=> {acc_o, carry_flag_o} == {$past(carry_flag_o), $past(acc_o)})
        else $error("rotate through carry wrong");

    a_carry_test_skip: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_SKIP_CARRY_ZERO) |=> skip_o == !$past(carry_flag_o))
        else $error("carry test skip wrong");

    a_skipped_is_nop: assert property (
        take && r_r.skip |=> $stable(acc_o) && $stable(carry_flag_o) && !mem_we_o && !rom_req_o && !skip_o)
        else $error("skipped instruction changed state");

    // logic, carry and complement results

    a_and_mem_result: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_AND_MEM) |=> acc_o == ($past(acc_o) & $past(mem_rdata_i)))
        else $error("and memory result wrong");

    a_or_mem_result: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_OR_MEM) |=> acc_o == ($past(acc_o) | $past(mem_rdata_i)))
        else $error("or memory result wrong");

    a_set_carry_only: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_SET_CARRY) |=> carry_flag_o && $stable(acc_o) && !mem_we_o)
        else $error("set carry wrong");

    a_reset_carry_only: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_RESET_CARRY) |=> !carry_flag_o && $stable(acc_o) && !mem_we_o)
        else $error("reset carry wrong");

    a_complement_acc: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_COMPLEMENT) |=> acc_o == ~$past(acc_o))
        else $error("complement wrong");

    // memory bit operations, compares and skip handling

    a_set_bit_write: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_SET_BIT)
        |=> mem_we_o && mem_wdata_o == ($past(mem_rdata_i) | $past(chk_mask)))
        else $error("set memory bit wrong");

    a_reset_bit_write: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_RESET_BIT)
        |=> mem_we_o && mem_wdata_o == ($past(mem_rdata_i) & ~$past(chk_mask)))
        else $error("reset memory bit wrong");

    a_bit_test_skip: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_SKIP_BIT_ZERO)
        |=> skip_o == (($past(mem_rdata_i) & $past(chk_mask)) == 4'h0))
        else $error("bit test skip wrong");

    a_mem_compare_skip: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_SKIP_EQ_MEM)
        |=> skip_o == ($past(acc_o) == $past(mem_rdata_i)))
        else $error("memory compare skip wrong");

    a_imm_compare_skip: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_SKIP_EQ_IMM)
        |=> skip_o == ($past(acc_o) == $past(chk_imm)))
        else $error("immediate compare skip wrong");

    a_add_imm_carry: assert property (
        exec && instr_op_i == 5'(nibble_alu_pkg::OP_ADD_IMM)
        |=> carry_flag_o == $past(carry_flag_o))
        else $error("add immediate changed carry");

    a_table_skipped: assert property (
        take && r_r.skip && instr_op_i == 5'(nibble_alu_pkg::OP_TABLE_READ)
        |=> instr_ready_o && !stack_hold_o && !rom_req_o)
        else $error("skipped table read started a fetch");

endmodule

// ---- hw/nibble_alu_pkg.sv ----
// constants, opcodes and register map of the nibble alu and skip datapath
package nibble_alu_pkg;

    // instruction codes presented on the issue port
    typedef enum logic [4:0] {
        OP_NOP             = 5'h00,
        OP_LOAD_IMM        = 5'h01,
        OP_TABLE_READ      = 5'h02,
        OP_ADD_MEM         = 5'h03,
        OP_ADD_MEM_CARRY   = 5'h04,
        OP_ADD_IMM         = 5'h05,
        OP_AND_MEM         = 5'h06,
        OP_OR_MEM          = 5'h07,
        OP_SET_CARRY       = 5'h08,
        OP_RESET_CARRY     = 5'h09,
        OP_SKIP_CARRY_ZERO = 5'h0A,
        OP_COMPLEMENT      = 5'h0B,
        OP_ROTATE_RIGHT    = 5'h0C,
        OP_SET_BIT         = 5'h0D,
        OP_RESET_BIT       = 5'h0E,
        OP_SKIP_BIT_ZERO   = 5'h0F,
        OP_SKIP_EQ_MEM     = 5'h10,
        OP_SKIP_EQ_IMM     = 5'h11
    } op_e;

    // table read sequencer, gray along idle -> wait
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1
    } tbl_state_e;

    // register map, byte addresses
    localparam logic [3:0] REG_CTRL       = 4'h0;
    localparam logic [3:0] REG_STATE      = 4'h4;
    localparam logic [3:0] REG_PAGE_OFS   = 4'h8;

    // field positions in the state and control registers
    localparam int ACC_LSB   = 0;
    localparam int AUX_LSB   = 4;
    localparam int OFS_LSB   = 8;
    localparam int CARRY_BIT = 12;
    localparam int SKIP_BIT  = 13;
    localparam int BUSY_BIT  = 14;
    localparam int UPPER_FLAG_BIT = 0;

    // values after reset
    localparam logic [3:0] ACC_RST   = 4'h0;
    localparam logic [3:0] AUX_RST   = 4'h0;
    localparam logic [2:0] OFS_RST   = 3'h0;
    localparam logic       CARRY_RST = 1'b0;
    localparam logic       UPPER_FLAG_RST = 1'b0;

endpackage

// ---- hw/nibble_alu_core.sv ----
// combinational nibble alu: results, carry and skip decision for one instruction
module nibble_alu_core (
    input  wire logic [4:0] op_i,       // instruction code
    input  wire logic [3:0] acc_i,      // accumulator
    input  wire logic [3:0] mem_i,      // nibble at the data pointer
    input  wire logic       carry_i,    // carry flag
    input  wire logic [3:0] imm_i,      // immediate n or bit index j
    output logic      [3:0] acc_o,      // new accumulator
    output logic            carry_o,    // new carry
    output logic      [3:0] mem_o,      // new memory nibble
    output logic            mem_we_o,   // memory nibble is written
    output logic            skip_o      // skip the next instruction
);
    logic [4:0] sum;
    logic [3:0] bit_mask;

    // one adder serves all three additions
    always_comb begin
        sum = {1'b0, acc_i} + {1'b0, (op_i == 5'(nibble_alu_pkg::OP_ADD_IMM)) ? imm_i : mem_i}
              + {4'h0, (op_i == 5'(nibble_alu_pkg::OP_ADD_MEM_CARRY)) & carry_i};
        bit_mask = 4'h1 << imm_i[1:0];
        acc_o = acc_i;
        carry_o = carry_i;
        mem_o = mem_i;
        mem_we_o = 1'b0;
        skip_o = 1'b0;
        case (op_i)
            5'(nibble_alu_pkg::OP_LOAD_IMM):        acc_o = imm_i;
            5'(nibble_alu_pkg::OP_ADD_MEM):         acc_o = sum[3:0];
            5'(nibble_alu_pkg::OP_ADD_MEM_CARRY): begin
                acc_o = sum[3:0];
                carry_o = sum[4];
            end
            5'(nibble_alu_pkg::OP_ADD_IMM): begin
                acc_o = sum[3:0];
                skip_o = ~sum[4];
            end
            5'(nibble_alu_pkg::OP_AND_MEM):         acc_o = acc_i & mem_i;
            5'(nibble_alu_pkg::OP_OR_MEM):          acc_o = acc_i | mem_i;
            5'(nibble_alu_pkg::OP_SET_CARRY):       carry_o = 1'b1;
            5'(nibble_alu_pkg::OP_RESET_CARRY):     carry_o = 1'b0;
            5'(nibble_alu_pkg::OP_SKIP_CARRY_ZERO): skip_o = ~carry_i;
            5'(nibble_alu_pkg::OP_COMPLEMENT):      acc_o = ~acc_i;
            5'(nibble_alu_pkg::OP_ROTATE_RIGHT): begin
                acc_o = {carry_i, acc_i[3:1]};
                carry_o = acc_i[0];
            end
            5'(nibble_alu_pkg::OP_SET_BIT): begin
                mem_o = mem_i | bit_mask;
                mem_we_o = 1'b1;
            end
            5'(nibble_alu_pkg::OP_RESET_BIT): begin
                mem_o = mem_i & ~bit_mask;
                mem_we_o = 1'b1;
            end
            5'(nibble_alu_pkg::OP_SKIP_BIT_ZERO):   skip_o = ~|(mem_i & bit_mask);
            5'(nibble_alu_pkg::OP_SKIP_EQ_MEM):     skip_o = (acc_i == mem_i);
            5'(nibble_alu_pkg::OP_SKIP_EQ_IMM):     skip_o = (acc_i == imm_i);
            default: ;
        endcase
    end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the nibble alu and skip datapath
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i, rstn_i, instr_valid_i, rom_valid_i, reg_we_i, reg_re_i;
    logic [4:0]  instr_op_i, instr_arg_i;
    logic [3:0]  mem_rdata_i, reg_addr_i, mem_wdata_o, acc_o, aux_o;
    logic [9:0]  rom_data_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    logic        instr_ready_o, mem_we_o, rom_req_o, stack_hold_o, skip_o, carry_flag_o;
    logic [11:0] rom_addr_o;
    logic [2:0]  page_ofs_o;
    int          error_cnt = 0;
    int          checks = 0;
    nibble_alu_datapath nibble_alu_datapath_inst (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i),
        .instr_arg_i(instr_arg_i), .instr_ready_o(instr_ready_o), .mem_rdata_i(mem_rdata_i),
        .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .rom_req_o(rom_req_o), .rom_addr_o(rom_addr_o),
        .rom_valid_i(rom_valid_i), .rom_data_i(rom_data_i), .stack_hold_o(stack_hold_o), .skip_o(skip_o),
        .acc_o(acc_o), .aux_o(aux_o), .page_ofs_o(page_ofs_o), .carry_flag_o(carry_flag_o),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and watchdog
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        #2000000;
        error_cnt++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // drivers: hold the instruction until an edge sees ready high
    task automatic issue(input logic [4:0] op, input logic [4:0] arg, input logic [3:0] m);
        int n = 0;
        @(posedge clk_sys_i);
        instr_valid_i <= 1'b1;
        instr_op_i <= op;
        instr_arg_i <= arg;
        mem_rdata_i <= m;
        @(posedge clk_sys_i);
        while (instr_ready_o !== 1'b1 && n < 40) begin
            n++;
            @(posedge clk_sys_i);
        end
        if (instr_ready_o !== 1'b1) begin
            error_cnt++;
        end
        instr_valid_i <= 1'b0;
        mem_rdata_i <= ~m;
        #1;
    endtask
    // issue, then compare accumulator, carry and pending skip
    task automatic step(input logic [4:0] op, input logic [4:0] arg, input logic [3:0] m,
                        input logic [3:0] ea, input logic ec, input logic es);
        issue(op, arg, m);
        `CHK(acc_o, ea)
        `CHK(carry_flag_o, ec)
        `CHK(skip_o, es)
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_sys_i);
        reg_we_i <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_re_i <= 1'b0;
        #1;
        `CHK(reg_rdata_o, e)
    endtask
    // rom answers after a stall, then drops valid and drives its data lines inverted
    task automatic rom_return(input logic [9:0] d);
        repeat (3) @(posedge clk_sys_i);
        rom_valid_i <= 1'b1;
        rom_data_i <= d;
        @(posedge clk_sys_i);
        rom_valid_i <= 1'b0;
        rom_data_i <= ~d;
        #1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_load;
        issue(nibble_alu_pkg::OP_LOAD_IMM, 5'h05, 4'h0); `CHK(acc_o, 4'h5)
        issue(nibble_alu_pkg::OP_LOAD_IMM, 5'h09, 4'h0); `CHK(acc_o, 4'h5)
        issue(nibble_alu_pkg::OP_LOAD_IMM, 5'h0A, 4'h0); `CHK(acc_o, 4'h5)
        issue(nibble_alu_pkg::OP_NOP, 5'h00, 4'h0);
        issue(nibble_alu_pkg::OP_LOAD_IMM, 5'h09, 4'h0); `CHK(acc_o, 4'h9)
        issue(nibble_alu_pkg::OP_NOP, 5'h00, 4'h0);
    endtask
    task automatic t_arith;
        step(nibble_alu_pkg::OP_SET_CARRY, 5'h00, 4'h0, 4'h9, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_ADD_MEM, 5'h00, 4'h9, 4'h2, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_RESET_CARRY, 5'h00, 4'h0, 4'h2, 1'b0, 1'b0);
        step(nibble_alu_pkg::OP_ADD_MEM_CARRY, 5'h00, 4'hF, 4'h1, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_ADD_MEM_CARRY, 5'h00, 4'hE, 4'h0, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_ADD_IMM, 5'h03, 4'h0, 4'h3, 1'b1, 1'b1);
        step(nibble_alu_pkg::OP_COMPLEMENT, 5'h00, 4'h0, 4'h3, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_ADD_IMM, 5'h0D, 4'h0, 4'h0, 1'b1, 1'b0);
    endtask
    task automatic t_logic;
        issue(nibble_alu_pkg::OP_LOAD_IMM, 5'h06, 4'h0);
        step(nibble_alu_pkg::OP_AND_MEM, 5'h00, 4'hD, 4'h4, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_OR_MEM, 5'h00, 4'h5, 4'h5, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_COMPLEMENT, 5'h00, 4'h0, 4'hA, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_ROTATE_RIGHT, 5'h00, 4'h0, 4'hD, 1'b0, 1'b0);
        step(nibble_alu_pkg::OP_ROTATE_RIGHT, 5'h00, 4'h0, 4'h6, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_SKIP_CARRY_ZERO, 5'h00, 4'h0, 4'h6, 1'b1, 1'b0);
        step(nibble_alu_pkg::OP_RESET_CARRY, 5'h00, 4'h0, 4'h6, 1'b0, 1'b0);
        step(nibble_alu_pkg::OP_SKIP_CARRY_ZERO, 5'h00, 4'h0, 4'h6, 1'b0, 1'b1);
        step(nibble_alu_pkg::OP_SET_CARRY, 5'h00, 4'h0, 4'h6, 1'b0, 1'b0);
    endtask
    task automatic t_compare;
        step(nibble_alu_pkg::OP_SKIP_EQ_MEM, 5'h00, 4'h6, 4'h6, 1'b0, 1'b1);
        step(nibble_alu_pkg::OP_COMPLEMENT, 5'h00, 4'h0, 4'h6, 1'b0, 1'b0);
        step(nibble_alu_pkg::OP_SKIP_EQ_MEM, 5'h00, 4'h7, 4'h6, 1'b0, 1'b0);
        step(nibble_alu_pkg::OP_SKIP_EQ_IMM, 5'h06, 4'h0, 4'h6, 1'b0, 1'b1);
        step(nibble_alu_pkg::OP_ROTATE_RIGHT, 5'h00, 4'h0, 4'h6, 1'b0, 1'b0);
        step(nibble_alu_pkg::OP_SKIP_EQ_IMM, 5'h0F, 4'h0, 4'h6, 1'b0, 1'b0);
    endtask
    task automatic t_bits;
        for (int j = 0; j < 4; j++) begin
            issue(nibble_alu_pkg::OP_SET_BIT, 5'(j), 4'h0); `CHK(mem_wdata_o, 4'(1 << j))
            `CHK(mem_we_o, 1'b1)
            issue(nibble_alu_pkg::OP_RESET_BIT, 5'(j), 4'hF); `CHK(mem_wdata_o, ~4'(1 << j))
            step(nibble_alu_pkg::OP_SKIP_BIT_ZERO, 5'(j), ~4'(1 << j), 4'h6, 1'b0, 1'b1);
            issue(nibble_alu_pkg::OP_SET_BIT, 5'(j), 4'h0); `CHK(mem_we_o, 1'b0)
            step(nibble_alu_pkg::OP_SKIP_BIT_ZERO, 5'(j), 4'(1 << j), 4'h6, 1'b0, 1'b0);
        end
    endtask
    task automatic t_table;
        reg_wr(nibble_alu_pkg::REG_PAGE_OFS, 32'h5);
        issue(nibble_alu_pkg::OP_TABLE_READ, 5'h13, 4'h0); `CHK(rom_addr_o, {5'h13, 3'h5, 4'h6})
        `CHK(stack_hold_o, 1'b1)
        `CHK(rom_req_o, 1'b1)
        rom_return(10'h3C7); `CHK({aux_o, acc_o, page_ofs_o}, {8'hC7, 3'h5})
        `CHK(stack_hold_o, 1'b0)
        reg_wr(nibble_alu_pkg::REG_CTRL, 32'h1);
        reg_wr(nibble_alu_pkg::REG_PAGE_OFS, 32'h7);
        issue(nibble_alu_pkg::OP_TABLE_READ, 5'h1F, 4'h0); `CHK(rom_addr_o, {5'h1F, 3'h7, 4'h7})
        rom_return(10'h2A5); `CHK({aux_o, acc_o, page_ofs_o}, {8'hA5, 3'h2})
        reg_rd(nibble_alu_pkg::REG_STATE, 32'h0000_02A5);
        reg_wr(4'hC, 32'hFFFF_FFFF);
        reg_rd(4'hC, 32'h0);
        reg_rd(nibble_alu_pkg::REG_CTRL, 32'h1);
        step(nibble_alu_pkg::OP_SKIP_EQ_IMM, 5'h05, 4'h0, 4'h5, 1'b0, 1'b1);
        issue(nibble_alu_pkg::OP_TABLE_READ, 5'h00, 4'h0); `CHK({rom_req_o, acc_o}, 5'h05)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic report_and_stop;
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // reset, then the scenarios in order
    initial begin
        {rstn_i, instr_valid_i, rom_valid_i, reg_we_i, reg_re_i} = '0;
        {instr_op_i, instr_arg_i, mem_rdata_i, reg_addr_i, rom_data_i, reg_wdata_i} = '0;
        repeat (12) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd(nibble_alu_pkg::REG_STATE, 32'h0);
        reg_rd(nibble_alu_pkg::REG_PAGE_OFS, 32'h0);
        t_load();
        t_arith();
        t_logic();
        t_compare();
        t_bits();
        t_table();
        report_and_stop();
    end
endmodule
